// [hdl/shr_home_seq.v]
/*
 * Home-return sequencer: starts a homing run, searches for the origin by
 * limit, home sensor edge, index pulse or present position, ramps a speed
 * profile, applies the offsets and flags completion.
 * Assumes pin inputs are asynchronous and the drive's position loop follows
 * the signed speed profile and loads the position counter on request.
 */
`timescale 1ns/1ps
`include "shr_regs.vh"
module shr_home_seq
(
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire [7:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg         wb_ack_o,
   output wire        wb_err_o,
   input  wire        homing_start_input,
   input  wire        home_sensor_in,
   input  wire        pos_limit_in,
   input  wire        neg_limit_in,
   input  wire        decel_in,
   input  wire        index_pulse_in,
   input  wire        servo_on,
   output reg  [15:0] speed_cmd,
   output reg         dir_neg,
   output reg         pos_load,
   output reg  [31:0] pos_load_value,
   output reg  [31:0] shift_cmd,
   output reg         shift_start,
   output reg         homing_done,
   output reg         homing_busy,
   output reg         alarm_timeout,
   output reg         alarm_limit,
   output wire        irq
);
   // Sequencer states.
   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_SRCH  = 3'd1;
   localparam [2:0] ST_INDEX = 3'd2;
   localparam [2:0] ST_STOP  = 3'd3;
   localparam [2:0] ST_DONE  = 3'd4;
   localparam [2:0] ST_ABORT = 3'd5;

   // Software registers.
   reg [31:0] ctrl_r;                   // Source, mode, limit handling; trigger bits are not stored.
   reg [15:0] fast_r;                   // High search speed.
   reg [15:0] slow_r;                   // Low search speed.
   reg [15:0] ramp_r;                   // Ramp time in ms, upper bound for a full speed change.
   reg [15:0] tlim_r;                   // Time limit in ms.
   reg [31:0] orgofs_r;                 // Origin coordinate offset.
   reg [31:0] mechsh_r;                 // Mechanical origin shift.
   reg [`SHR_IRQ_W-1:0] irq_stat_r;     // Sticky events.
   reg [`SHR_IRQ_W-1:0] irq_en_r;       // Event enables.
   reg [31:0] pos_r;                    // Absolute position seen by software.

   // Two-stage synchronisers for the seven pins.
   reg [6:0] sync1_r;
   reg [6:0] sync2_r;
   reg [6:0] prev_r;                    // Last synchronised sample for edges.

   // Sequencer working state.
   reg [2:0]  state_r;
   reg        fast_phase_r;             // High speed selected.
   reg        searching_neg_r;          // Present search direction.
   reg [15:0] target_r;                 // Speed the ramp heads for.
   reg [`SHR_MS_CNT_W-1:0] ms_cnt_r;    // Cycle divider to one millisecond.
   reg [15:0] ms_elapsed_r;             // Milliseconds since start.
   reg        pwron_armed_r;            // Power-on start not yet used.

   wire [2:0] src  = ctrl_r[`SHR_CTRL_SRC_LSB+2:`SHR_CTRL_SRC_LSB];
   wire [3:0] mode = ctrl_r[`SHR_CTRL_MODE_LSB+3:`SHR_CTRL_MODE_LSB];
   wire [2:0] lim  = ctrl_r[`SHR_CTRL_LIM_LSB+2:`SHR_CTRL_LIM_LSB];

   // Synchronised pin levels.
   wire s_start = sync2_r[0];
   wire s_home  = sync2_r[1];
   wire s_plim  = sync2_r[2];
   wire s_nlim  = sync2_r[3];
   wire s_dec   = sync2_r[4];
   wire s_idx   = sync2_r[5];
   wire s_son   = sync2_r[6];
   wire start_rise = s_start & ~prev_r[0];
   wire idx_rise   = s_idx & ~prev_r[5];
   wire son_rise   = s_son & ~prev_r[6];

   // Wishbone strobes: registered answer one cycle after the request, ack falls the cycle after.
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr  = bus_req & wb_we_i;
   assign wb_err_o = 1'b0;

   // Mode classes, decoded once and reused by the sequencer.
   function is_sensor_mode;
      input [3:0] m;
      begin
         is_sensor_mode = (m >= 4'h2) && (m <= 4'h5);
      end
   endfunction

   // Odd modes search in the negative direction.
   function mode_neg;
      input [3:0] m;
      begin
         mode_neg = m[0];
      end
   endfunction

   // Byte-lane merge for 32-bit writes.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (sel[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   // Start request decode by source selection.
   wire cmd_wr = bus_wr && (wb_adr_i == `SHR_ADDR_CTRL) && wb_sel_i[1];
   wire start_req =
      ((src == `SHR_SRC_DI)    && start_rise) ||
      ((src == `SHR_SRC_KEY)   && cmd_wr && wb_dat_i[`SHR_CTRL_KEY_BIT]) ||
      ((src == `SHR_SRC_COMM)  && cmd_wr && wb_dat_i[`SHR_CTRL_CMD_BIT]) ||
      ((src == `SHR_SRC_PWRON) && pwron_armed_r && son_rise);
   // A start that the sequencer accepts; it also restarts the run timer.
   wire run_start = start_req &&
                    (state_r == ST_IDLE || state_r == ST_DONE || state_r == ST_ABORT);

   // Home-sensor edge that marks the origin for modes 2-5.
   wire sensor_edge = (mode < 4'h4) ? (s_home & ~prev_r[1]) : (~s_home & prev_r[1]);
   // Limit ahead in the present search direction.
   wire lim_ahead = searching_neg_r ? s_nlim : s_plim;
   wire idx_skip  = (lim == 3'h2) || (lim == 3'h5);
   wire idx_back  = (lim == 3'h0) || (lim == 3'h3);
   wire ms_tick   = (ms_cnt_r == `SHR_MS_CYCLES - 1);
   wire timed_out = (ms_elapsed_r >= tlim_r);
   wire ramp_idle = (speed_cmd == 16'h0000);
   // Time limit hit in a running state; a stop that has just settled completes instead.
   wire abort_timeout = (state_r == ST_SRCH || state_r == ST_INDEX || state_r == ST_STOP) &&
                        timed_out && !(state_r == ST_STOP && ramp_idle);

   // Input synchronisers; the first stage feeds only the second.
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
         prev_r  <= 7'h00;
      end
      else
      begin
         sync1_r <= {servo_on, index_pulse_in, decel_in, neg_limit_in,
                     pos_limit_in, home_sensor_in, homing_start_input};
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Lane merge of the fast speed; only the low half is kept.
   wire [31:0] fast_merged = merge({16'h0000, fast_r}, wb_dat_i, wb_sel_i);

   // Register writes and bus acknowledge.
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         wb_ack_o <= 1'b0;
         ctrl_r   <= `SHR_CTRL_RST;
         fast_r   <= `SHR_FAST_RST;
         slow_r   <= `SHR_SLOW_RST;
         ramp_r   <= `SHR_RAMP_RST;
         tlim_r   <= `SHR_TLIM_RST;
         orgofs_r <= 32'h0000_0000;
         mechsh_r <= 32'h0000_0000;
         irq_en_r <= {`SHR_IRQ_W{1'b0}};
      end
      else
      begin
         wb_ack_o <= bus_req;
         if (bus_wr)
         begin
            // Trigger bits self-clear; only settings are stored.
            if (wb_adr_i == `SHR_ADDR_CTRL)
               ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0FFF;
            else if (wb_adr_i == `SHR_ADDR_FAST)
               fast_r <= fast_merged[15:0];
            else if (wb_adr_i == `SHR_ADDR_SLOW)
               slow_r <= wb_sel_i[0] ? wb_dat_i[15:0] : slow_r;
            else if (wb_adr_i == `SHR_ADDR_RAMP)
               ramp_r <= wb_sel_i[0] ? wb_dat_i[15:0] : ramp_r;
            else if (wb_adr_i == `SHR_ADDR_TLIM)
               tlim_r <= wb_sel_i[0] ? wb_dat_i[15:0] : tlim_r;
            else if (wb_adr_i == `SHR_ADDR_ORGOFS)
               orgofs_r <= merge(orgofs_r, wb_dat_i, wb_sel_i);
            else if (wb_adr_i == `SHR_ADDR_MECHSH)
               mechsh_r <= merge(mechsh_r, wb_dat_i, wb_sel_i);
            else if (wb_adr_i == `SHR_ADDR_IRQ_EN)
               irq_en_r <= wb_dat_i[`SHR_IRQ_W-1:0];
         end
      end
   end

   // Read multiplexer; unmapped addresses read zero.
   always @(posedge mclk)
   begin
      if (sys_rst)
         wb_dat_o <= 32'h0000_0000;
      else if (bus_req)
      begin
         if (wb_adr_i == `SHR_ADDR_CTRL)
            wb_dat_o <= ctrl_r;
         else if (wb_adr_i == `SHR_ADDR_FAST)
            wb_dat_o <= {16'h0000, fast_r};
         else if (wb_adr_i == `SHR_ADDR_SLOW)
            wb_dat_o <= {16'h0000, slow_r};
         else if (wb_adr_i == `SHR_ADDR_RAMP)
            wb_dat_o <= {16'h0000, ramp_r};
         else if (wb_adr_i == `SHR_ADDR_TLIM)
            wb_dat_o <= {16'h0000, tlim_r};
         else if (wb_adr_i == `SHR_ADDR_ORGOFS)
            wb_dat_o <= orgofs_r;
         else if (wb_adr_i == `SHR_ADDR_MECHSH)
            wb_dat_o <= mechsh_r;
         else if (wb_adr_i == `SHR_ADDR_STATUS)
            wb_dat_o <= {24'h00_0000, searching_neg_r, fast_phase_r, state_r,
                         alarm_limit, alarm_timeout, homing_done};
         else if (wb_adr_i == `SHR_ADDR_POS)
            wb_dat_o <= pos_r;
         else if (wb_adr_i == `SHR_ADDR_SPEED)
            wb_dat_o <= {16'h0000, speed_cmd};
         else if (wb_adr_i == `SHR_ADDR_IRQ_STAT)
            wb_dat_o <= {29'h0000_0000, irq_stat_r};
         else if (wb_adr_i == `SHR_ADDR_IRQ_EN)
            wb_dat_o <= {29'h0000_0000, irq_en_r};
         else
            wb_dat_o <= 32'h0000_0000;
      end
   end

   // Interrupt status: a new event wins over a clear in the same cycle.
   wire ev_done    = pos_load;
   wire ev_timeout = abort_timeout;     // One cycle: the sequencer leaves the run at once.
   reg  ev_limit;                       // Pulse from the sequencer on a limit alarm.
   wire [`SHR_IRQ_W-1:0] ev_vec = {ev_limit, ev_timeout, ev_done};
   wire irq_clr_wr = bus_wr && (wb_adr_i == `SHR_ADDR_IRQ_CLR);

   always @(posedge mclk)
   begin
      if (sys_rst)
         irq_stat_r <= {`SHR_IRQ_W{1'b0}};
      else
         irq_stat_r <= (irq_stat_r & ~(irq_clr_wr ? wb_dat_i[`SHR_IRQ_W-1:0]
                                                  : {`SHR_IRQ_W{1'b0}})) | ev_vec;
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // Millisecond base and elapsed time, both restarted by an accepted start so that a
   // later run is not charged with the time spent in the done or abort state.
   always @(posedge mclk)
   begin
      if (sys_rst || run_start)
      begin
         ms_cnt_r     <= {`SHR_MS_CNT_W{1'b0}};
         ms_elapsed_r <= 16'h0000;
      end
      else
      begin
         ms_cnt_r <= ms_tick ? {`SHR_MS_CNT_W{1'b0}} : ms_cnt_r + 1'b1;
         if (ms_tick && ms_elapsed_r != 16'hFFFF)
            ms_elapsed_r <= ms_elapsed_r + 1'b1;
      end
   end

   // Speed ramp: speed moves by fast_r / ramp_r + 1 each ms, so zero to fast speed takes at most ramp_r ms.
   always @(posedge mclk)
   begin
      if (sys_rst)
         speed_cmd <= 16'h0000;
      else if (ramp_r == 16'h0000)
         speed_cmd <= target_r;
      else if (ms_tick)
      begin
         if (speed_cmd < target_r)
            speed_cmd <= (target_r - speed_cmd > fast_r / ramp_r + 16'h0001) ?
                         speed_cmd + fast_r / ramp_r + 16'h0001 : target_r;
         else if (speed_cmd > target_r)
            speed_cmd <= (speed_cmd - target_r > fast_r / ramp_r + 16'h0001) ?
                         speed_cmd - fast_r / ramp_r - 16'h0001 : target_r;
      end
   end

   // Main homing sequencer.
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         state_r         <= ST_IDLE;
         fast_phase_r    <= 1'b0;
         searching_neg_r <= 1'b0;
         target_r        <= 16'h0000;
         dir_neg         <= 1'b0;
         pos_load        <= 1'b0;
         pos_load_value  <= 32'h0000_0000;
         pos_r           <= 32'h0000_0000;
         shift_cmd       <= 32'h0000_0000;
         shift_start     <= 1'b0;
         homing_done     <= 1'b0;
         homing_busy     <= 1'b0;
         alarm_timeout   <= 1'b0;
         alarm_limit     <= 1'b0;
         ev_limit        <= 1'b0;
         pwron_armed_r   <= 1'b1;
      end
      else
      begin
         pos_load    <= 1'b0;
         shift_start <= 1'b0;
         ev_limit    <= 1'b0;
         if (son_rise)
            pwron_armed_r <= 1'b0;
         case (state_r)
            ST_IDLE, ST_DONE, ST_ABORT:
            begin
               target_r <= 16'h0000;
               if (start_req && src != `SHR_SRC_OFF)
               begin
                  homing_done   <= 1'b0;
                  alarm_timeout <= 1'b0;
                  alarm_limit   <= 1'b0;
                  homing_busy   <= 1'b1;
                  searching_neg_r <= mode_neg(mode);
                  dir_neg       <= mode_neg(mode);
                  if (mode == `SHR_MODE_HERE || mode > `SHR_MODE_HERE)
                  begin
                     state_r <= ST_STOP;
                  end
                  else if (mode == `SHR_MODE_IDX_FWD || mode == `SHR_MODE_IDX_REV)
                  begin
                     state_r      <= ST_INDEX;
                     fast_phase_r <= 1'b0;
                     target_r     <= slow_r;
                  end
                  else
                  begin
                     state_r      <= ST_SRCH;
                     fast_phase_r <= ~(s_dec | s_home);
                     target_r     <= (s_dec | s_home) ? slow_r : fast_r;
                  end
               end
            end
            ST_SRCH:
            begin
               if (s_dec && fast_phase_r)
               begin
                  fast_phase_r <= 1'b0;
                  target_r     <= slow_r;
               end
               if (!is_sensor_mode(mode) && lim_ahead)
               begin
                  // The limit is the origin here and never alarms.
                  if (idx_skip)
                     state_r <= ST_STOP;
                  else
                  begin
                     state_r <= ST_INDEX;
                     searching_neg_r <= idx_back ? ~searching_neg_r : searching_neg_r;
                     dir_neg  <= idx_back ? ~searching_neg_r : searching_neg_r;
                     target_r <= slow_r;
                  end
               end
               else if (is_sensor_mode(mode) && sensor_edge)
               begin
                  target_r <= slow_r;
                  if (idx_skip)
                     state_r <= ST_STOP;
                  else
                  begin
                     state_r <= ST_INDEX;
                     searching_neg_r <= idx_back ? ~searching_neg_r : searching_neg_r;
                     dir_neg <= idx_back ? ~searching_neg_r : searching_neg_r;
                  end
               end
               else if (lim_ahead)
               begin
                  if (lim >= `SHR_LIM_STOP_MIN)
                  begin
                     state_r       <= ST_ABORT;
                     alarm_limit   <= 1'b1;
                     ev_limit      <= 1'b1;
                     homing_done   <= 1'b0;
                     homing_busy   <= 1'b0;
                  end
                  else
                  begin
                     searching_neg_r <= ~searching_neg_r;
                     dir_neg         <= ~searching_neg_r;
                  end
               end
            end
            ST_INDEX:
            begin
               if (idx_rise)
                  state_r <= ST_STOP;
            end
            ST_STOP:
            begin
               target_r <= 16'h0000;
               if (ramp_idle)
               begin
                  pos_load       <= 1'b1;
                  pos_load_value <= orgofs_r;
                  pos_r          <= orgofs_r;
                  shift_cmd      <= mechsh_r;
                  shift_start    <= (mechsh_r != 32'h0000_0000);
                  homing_done    <= 1'b1;
                  homing_busy    <= 1'b0;
                  state_r        <= ST_DONE;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
         if (abort_timeout)
         begin
            state_r       <= ST_ABORT;
            target_r      <= 16'h0000;
            alarm_timeout <= 1'b1;
            homing_done   <= 1'b0;
            homing_busy   <= 1'b0;
         end
      end
   end
endmodule

// [hdl/shr_regs.vh]
/*
 * Register map, field codes and timing constants of the home-return sequencer.
 * Assumes a 40 MHz system clock and a classic Wishbone slave with 32-bit data.
 */
`ifndef SHR_REGS_VH
`define SHR_REGS_VH
// Byte addresses of the registers.
`define SHR_ADDR_CTRL      8'h00
`define SHR_ADDR_FAST      8'h04
`define SHR_ADDR_SLOW      8'h08
`define SHR_ADDR_RAMP      8'h0C
`define SHR_ADDR_TLIM      8'h10
`define SHR_ADDR_ORGOFS    8'h14
`define SHR_ADDR_MECHSH    8'h18
`define SHR_ADDR_STATUS    8'h1C
`define SHR_ADDR_POS       8'h20
`define SHR_ADDR_SPEED     8'h24
`define SHR_ADDR_IRQ_STAT  8'h28
`define SHR_ADDR_IRQ_EN    8'h2C
`define SHR_ADDR_IRQ_CLR   8'h30
// Fields of the control register.
`define SHR_CTRL_SRC_LSB   0
`define SHR_CTRL_MODE_LSB  4
`define SHR_CTRL_LIM_LSB   8
`define SHR_CTRL_CMD_BIT   12
`define SHR_CTRL_KEY_BIT   13
// Start source codes.
`define SHR_SRC_OFF        3'h0
`define SHR_SRC_DI         3'h1
`define SHR_SRC_KEY        3'h2
`define SHR_SRC_COMM       3'h3
`define SHR_SRC_PWRON      3'h4
// Search mode codes.
`define SHR_MODE_POS_LIM   4'h0
`define SHR_MODE_NEG_LIM   4'h1
`define SHR_MODE_IDX_FWD   4'h6
`define SHR_MODE_IDX_REV   4'h7
`define SHR_MODE_HERE      4'h8
// Limit handling codes.
`define SHR_LIM_STOP_MIN   3'h3
// Reset values.
`define SHR_CTRL_RST       32'h0000_0000
`define SHR_FAST_RST       16'h0064
`define SHR_SLOW_RST       16'h000A
`define SHR_RAMP_RST       16'h0064
`define SHR_TLIM_RST       16'h2710
// Timing: one millisecond at 40 MHz.
`define SHR_CLK_HZ         40000000
`define SHR_MS_CYCLES      (`SHR_CLK_HZ / 1000)
`define SHR_MS_CNT_W       16
// Interrupt status bits.
`define SHR_IRQ_DONE       0
`define SHR_IRQ_TIMEOUT    1
`define SHR_IRQ_LIMIT      2
`define SHR_IRQ_W          3
`endif

// [verification/shr_axis_model.sv]
/* Behavioural axis: integrates the speed profile into a position and drives
   the sensors from it. Assumes speed_cmd and dir_neg come from the sequencer. */
`timescale 1ns/1ps
module shr_axis_model
#(
   parameter int LIMIT_AT = 1 << 30,
   parameter int HOME_AT  = 1 << 29
)
(
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire [15:0] speed_cmd,
   input  wire        dir_neg,
   output logic       home_sensor_in,
   output logic       pos_limit_in,
   output logic       neg_limit_in,
   output logic       decel_in,
   output logic       index_pulse_in
);
   int pos_r; // Shaft position in counts.
   // Sensors sit far out, so a short run never reaches them and can time out.
   always @(posedge mclk)
      if (sys_rst)
         pos_r <= 0;
      else
         pos_r <= dir_neg ? pos_r - int'(speed_cmd) : pos_r + int'(speed_cmd);
   assign home_sensor_in = pos_r >= HOME_AT;
   assign pos_limit_in   = pos_r >= LIMIT_AT;
   assign neg_limit_in   = pos_r <= -LIMIT_AT;
   assign decel_in       = pos_r >= HOME_AT - 4096;
   assign index_pulse_in = pos_r[19:0] < 20'h0_0040; // Once per turn.
endmodule

// [verification/shr_home_seq_assertions.sv]
/* Concurrent checks on the ports of the home-return sequencer.
   Assumes it is bound to shr_home_seq and shares its clock mclk and reset. */
`timescale 1ns/1ps
module shr_home_checker
(
   input wire mclk,
   input wire sys_rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire pos_load,
   input wire shift_start,
   input wire homing_done,
   input wire homing_busy,
   input wire alarm_timeout,
   input wire alarm_limit
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_ack_in_one: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus answer missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus answer too long");
   a_err_quiet: assert property (!wb_err_o)
      else $error("bus error raised");
   a_load_at_done: assert property ($rose(homing_done) |-> pos_load)
      else $error("position load missing at completion");
   a_load_pulse: assert property (pos_load |=> !pos_load)
      else $error("position load longer than one cycle");
   a_done_idle: assert property (homing_done |-> !homing_busy)
      else $error("completion shown while busy");
   a_start_clears: assert property ($rose(homing_busy) |-> !homing_done)
      else $error("completion kept at new start");
   a_alarm_clears: assert property (alarm_timeout || alarm_limit |-> !homing_done)
      else $error("completion kept under alarm");
   a_shift_single: assert property (shift_start |=> !shift_start)
      else $error("shift start longer than one cycle");
endmodule

// [verification/shr_home_seq_tb.sv]
/* Self-checking bench of the home-return sequencer over Wishbone.
   Assumes the register map of shr_regs.vh and the axis model as partner. */
`timescale 1ns/1ps
`include "shr_regs.vh"
module shr_home_seq_tb;
   logic mclk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, start_in = 0, servo_on = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, pos_val, shift_val;
   logic [3:0] sel = 4'hF;
   logic ack, err, home, plim, nlim, decel, idx, load, sh_st, done, busy, a_to, a_li, irq, dn;
   logic [15:0] speed;
   int errors = 0, samples_checked = 0;
   shr_home_seq dut_u (.mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .wb_err_o(err), .homing_start_input(start_in), .home_sensor_in(home),
      .pos_limit_in(plim), .neg_limit_in(nlim), .decel_in(decel), .index_pulse_in(idx),
      .servo_on(servo_on), .speed_cmd(speed), .dir_neg(dn), .pos_load(load),
      .pos_load_value(pos_val), .shift_cmd(shift_val), .shift_start(sh_st),
      .homing_done(done), .homing_busy(busy), .alarm_timeout(a_to), .alarm_limit(a_li),
      .irq(irq));
   shr_axis_model #(.HOME_AT(65536)) axis_u (.mclk(mclk), .sys_rst(sys_rst), .speed_cmd(speed),
      .dir_neg(dn), .home_sensor_in(home), .pos_limit_in(plim), .neg_limit_in(nlim),
      .decel_in(decel),
      .index_pulse_in(idx));
   initial forever #12.5 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; the request stands until ack is seen at an edge.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      do begin @(posedge mclk); n++; end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) errors++;   // A bus that never answers counts as a mismatch.
      q = rdat;
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge mclk);
   endtask
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (done !== 1'b1 && n < lim) begin @(posedge mclk); n++; end
   endtask
   // Runs a mode 8 homing from the given source; kick picks how it starts.
   task automatic run_here(input logic [2:0] src, input int kick);
      logic [31:0] q;
      // The source is stored first: a trigger obeys the source already in place.
      wb(1, `SHR_ADDR_CTRL, {20'h0_0000, 4'h0, 4'h8, 1'b0, src}, q);
      wb(1, `SHR_ADDR_CTRL, {18'h0, kick == 1, kick == 0, 4'h0, 4'h8, 1'b0, src}, q);
      if (kick == 2) start_in <= 1;
      if (kick == 3) servo_on <= 1;
      wait_done(40);
      chk(done, 1);
      chk(pos_val, 32'h1234_5678);
      chk(shift_val, 32'h0000_0010);
      wb(0, `SHR_ADDR_STATUS, 0, q);
      chk(q[0], 1);
      start_in <= 0;
   endtask
   task automatic tally_and_finish;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin : main
      logic [31:0] q;
      int n;
      repeat (4) @(posedge mclk);
      sys_rst <= 0;
      @(posedge mclk);
      wb(0, `SHR_ADDR_FAST, 0, q); chk(q, 32'h0000_0064);
      wb(0, `SHR_ADDR_TLIM, 0, q); chk(q, 32'h0000_2710);
      wb(0, 8'h40, 0, q); chk(q, 32'h0000_0000);
      // Source off: neither trigger bit nor the start pin may begin a run.
      wb(1, `SHR_ADDR_CTRL, 32'h0000_3080, q);
      start_in <= 1;
      repeat (20) @(posedge mclk);
      chk(busy | done, 0);
      start_in <= 0;
      wb(1, `SHR_ADDR_ORGOFS, 32'h1234_5678, q);
      wb(1, `SHR_ADDR_MECHSH, 32'h0000_0010, q);
      wb(1, `SHR_ADDR_RAMP, 32'h0000_0001, q);
      run_here(`SHR_SRC_COMM, 0);
      wb(0, `SHR_ADDR_IRQ_STAT, 0, q); chk(q[0], 1);
      chk(irq, 0);
      wb(1, `SHR_ADDR_IRQ_EN, 32'h0000_0007, q); chk(irq, 1);
      wb(1, `SHR_ADDR_IRQ_CLR, 32'h0000_0001, q); chk(irq, 0);
      run_here(`SHR_SRC_KEY, 1);
      run_here(`SHR_SRC_DI, 2);
      run_here(`SHR_SRC_PWRON, 3);
      // Forward sensor search: fast until decel, slow to the rising edge, no index.
      wb(1, `SHR_ADDR_RAMP, 32'h0000_0000, q);
      wb(1, `SHR_ADDR_CTRL, 32'h0000_0223, q);
      wb(1, `SHR_ADDR_CTRL, 32'h0000_1223, q);
      chk(speed, 16'h0064);
      chk(dn, 0);
      wait_done(3000);
      chk(done, 1);
      chk(a_li, 0);
      chk(speed, 16'h0000);
      chk(pos_val, 32'h1234_5678);
      wb(0, `SHR_ADDR_STATUS, 0, q); chk(q[6], 0);
      // Reverse search from on the sensor: no rising edge, so it times out after 1 ms.
      wb(1, `SHR_ADDR_TLIM, 32'h0000_0001, q);
      wb(1, `SHR_ADDR_CTRL, 32'h0000_0033, q);
      wb(1, `SHR_ADDR_CTRL, 32'h0000_1033, q);
      chk(speed, 16'h000A);
      chk(dn, 1);
      n = 0;
      while (a_to !== 1'b1 && n < 45000) begin @(posedge mclk); n++; end
      chk(a_to, 1);
      chk(done, 0);
      wb(0, `SHR_ADDR_IRQ_STAT, 0, q); chk(q[1], 1);
      chk(irq, 1);
      tally_and_finish;
   end
   initial
   begin
      repeat (90000) @(posedge mclk);
      errors++;
      tally_and_finish;
   end
endmodule
bind shr_home_seq shr_home_checker chk_u (.mclk(mclk), .sys_rst(sys_rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .pos_load(pos_load), .shift_start(shift_start), .homing_done(homing_done),
   .homing_busy(homing_busy), .alarm_timeout(alarm_timeout), .alarm_limit(alarm_limit));
